// ### irqf_evsrc.sv
// Model of the peripheral event sources.
// Drives one-cycle event pulses just after a rising edge of hclk.
`timescale 1ns/1ns
`default_nettype none
module irqf_evsrc (
   // Clock and events
   input wire logic                  hclk,
   output var irqf_pkg::irqf_events_t events
);
   initial events = '0;
   task automatic pulse(input irqf_pkg::irqf_events_t v);
      @(posedge hclk);
      events <= v;
      @(posedge hclk);
      events <= '0;
   endtask
endmodule
`default_nettype wire

// ### irqf_monitor.sv
// Checker on the ports of the interrupt enable and flag block.
// Assumes one master; a write lands at the edge that ends its data phase.
`timescale 1ns/1ns
`default_nettype none
module irqf_monitor (
   // Bus
   input wire logic                   hclk,
   input wire logic                   hresetn,
   input wire logic                   hsel,
   input wire logic [31:0]            haddr,
   input wire logic [1:0]             htrans,
   input wire logic                   hwrite,
   input wire logic [31:0]            hwdata,
   input wire logic                   hready,
   input wire logic                   hreadyout,
   input wire logic                   hresp,
   input wire logic [31:0]            hrdata,
   // Events and status
   input wire irqf_pkg::irqf_events_t events,
   input wire irqf_pkg::irqf_status_t status
);
   logic        wr_dp;
   logic [15:0] wr_idx;
   // Marks the data phase of a write inside the window, aligned or not, when registers may change.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) wr_dp <= 1'b0;
      else wr_dp <= hsel && hready && htrans == 2'b10 && hwrite && haddr[31:18] == '0;
   end
   always_ff @(posedge hclk) wr_idx <= haddr[17:2];
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   property p_rst; $rose(hresetn) |-> status == '0 && hrdata == '0; endproperty
   a_rst: assert property (p_rst) else $error("state not clear after reset");
   property p_hi; hreadyout && !hresp && hrdata[31:8] == '0; endproperty
   a_hi: assert property (p_hi) else $error("bus answer or upper bits wrong");
   property p_port; events.port != '0 |=> (status.port_irq_flags & $past(events.port)) == $past(events.port); endproperty
   a_port: assert property (p_port) else $error("port flag not set");
   property p_lt; events.lower_timer != '0 |=> (status.lower_timer_irq_flags & $past(events.lower_timer)) == $past(events.lower_timer); endproperty
   a_lt: assert property (p_lt) else $error("timer flag not set");
   property p_hold; !wr_dp && events.port == '0 |=> $stable(status.port_irq_flags); endproperty
   a_hold: assert property (p_hold) else $error("port flags moved alone");
   property p_w1c; wr_dp && wr_idx == 16'hff1a && events.port == '0 |=> (status.port_irq_flags & $past(hwdata[7:0])) == '0; endproperty
   a_w1c: assert property (p_w1c) else $error("port flag not cleared");
   property p_en; !wr_dp |=> $stable(status.clock_timer_irq_enable) && $stable(status.upper_timer_irq_enable); endproperty
   a_en: assert property (p_en) else $error("enable moved without write");
   property p_req; !wr_dp && events.serial == '0 |=> $stable(status.serial_irq_req); endproperty
   a_req: assert property (p_req) else $error("request moved alone");
   c_ev: cover property (events.port != '0);
   c_wr: cover property (wr_dp && wr_idx == 16'hff1a);
   c_req: cover property ($rose(|status.serial_irq_req));
endmodule
bind irqf_top irqf_monitor mon_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
   .hresp(hresp), .hrdata(hrdata), .events(events), .status(status));
`default_nettype wire

// ### irqf_pkg.sv
// Package for the interrupt enable and factor flag block.
// Holds the register indices, bit layouts, reset values and the packed carriers
// that the block and its surroundings share.
package irqf_pkg;

   // Register indices; byte address on the bus is four times the index.
   localparam logic [15:0] IDX_SERIAL_IRQ_ENABLE      = 16'hff16;
   localparam logic [15:0] IDX_CLOCK_TIMER_IRQ_ENABLE = 16'hff17;
   localparam logic [15:0] IDX_UPPER_TIMER_IRQ_ENABLE = 16'hff18;
   localparam logic [15:0] IDX_PORT_IRQ_FLAGS         = 16'hff1a;
   localparam logic [15:0] IDX_LOWER_TIMER_IRQ_FLAGS  = 16'hff1b;
   localparam logic [15:0] IDX_SERIAL_IRQ_FLAGS       = 16'hff1c;

   // Implemented bits of each register; all other bits read as zero.
   localparam logic [7:0] MASK_SERIAL      = 8'h3f;
   localparam logic [7:0] MASK_CLOCK_TIMER = 8'h0f;
   localparam logic [7:0] MASK_FULL        = 8'hff;

   // Reset values.
   localparam logic [7:0] RST_ENABLE = 8'h00;
   localparam logic [7:0] RST_FLAGS  = 8'h00;

   // Serial field positions, used for both enables and flags.
   localparam int SER1_ERROR    = 5;
   localparam int SER1_RECEIVE  = 4;
   localparam int SER1_TRANSMIT = 3;
   localparam int SER0_ERROR    = 2;
   localparam int SER0_RECEIVE  = 1;
   localparam int SER0_TRANSMIT = 0;

   // Clock timer enable positions.
   localparam int TICK_32HZ = 3;
   localparam int TICK_8HZ  = 2;
   localparam int TICK_2HZ  = 1;
   localparam int TICK_1HZ  = 0;

   // Lower timer flag positions; timer 0 has its pair swapped.
   localparam int TIMER3_COMPARE   = 7;
   localparam int TIMER3_UNDERFLOW = 6;
   localparam int TIMER0_UNDERFLOW = 1;
   localparam int TIMER0_COMPARE   = 0;

   // AHB encodings.
   localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
   localparam logic       HRESP_OKAY    = 1'b0;

   // Event pulses from peripherals, one cycle each, laid out as the flag bits.
   typedef struct packed {
      logic [7:0] port;
      logic [7:0] lower_timer;
      logic [5:0] serial;
   } irqf_events_t;

   // Register contents presented to the priority logic.
   typedef struct packed {
      logic [5:0] serial_irq_req;
      logic [3:0] clock_timer_irq_enable;
      logic [7:0] upper_timer_irq_enable;
      logic [7:0] port_irq_flags;
      logic [7:0] lower_timer_irq_flags;
   } irqf_status_t;

   // Whole state of the block.
   typedef struct packed {
      logic        dp_valid;
      logic        dp_write;
      logic [15:0] dp_index;
      logic        dp_mapped;
      logic [7:0]  rdata;
      logic [5:0]  serial_irq_enable;
      logic [3:0]  clock_timer_irq_enable;
      logic [7:0]  upper_timer_irq_enable;
      logic [7:0]  port_irq_flags;
      logic [7:0]  lower_timer_irq_flags;
      logic [5:0]  serial_irq_flags;
   } irqf_state_t;

endpackage

// ### irqf_top.sv
// Interrupt enable registers and interrupt factor flags, reached over AHB-Lite.
// Assumes a single AHB-Lite master, event pulses from logic on hclk, and an
// outside priority stage that consumes the exported enables, flags and requests.
//
// Summary of operation
// - Serial enables: interface 1 error/receive/transmit bits 5-3, interface 0 bits 2-0.
// - Clock timer enables 32, 8, 2, 1 Hz in bits 3 to 0.
// - Timers 7-4 enables paired, compare in odd bit, underflow in even bit.
// - Port input 7 to 0 factor flags in bits 7 to 0.
// - Timers 3-1 flags compare-high pairs; timer 0 underflow bit 1, compare bit 0.
// - Serial flags: interface 1 in bits 5-3, interface 0 in bits 2-0.
// - A flag reads 1 once its cause occurred, 0 otherwise.
// - Writing 1 clears a flag, writing 0 leaves it alone.
// - Reset clears all enables and all flags.
//
// Implementation choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none

module irqf_top (
   // Clock and reset
   input  wire logic                  hclk,
   input  wire logic                  hresetn,
   // AHB-Lite slave
   input  wire logic                  hsel,
   input  wire logic [31:0]           haddr,
   input  wire logic [1:0]            htrans,
   input  wire logic                  hwrite,
   input  wire logic [2:0]            hsize,
   input  wire logic [31:0]           hwdata,
   input  wire logic                  hready,
   output logic                       hreadyout,
   output logic                       hresp,
   output logic [31:0]                hrdata,
   // Peripheral events
   input  wire irqf_pkg::irqf_events_t events,
   // Toward the priority logic
   output irqf_pkg::irqf_status_t     status
);

   irqf_pkg::irqf_state_t state;
   irqf_pkg::irqf_state_t next_state;

   logic       addr_phase;
   logic       wr_en;
   logic [7:0] wbyte;
   logic [7:0] rd_mux;

   // Decode of the address phase being taken.
   logic        addr_in_window;
   logic        addr_aligned;
   logic [15:0] addr_index;

   // Strobes for the data phase that ends at the coming edge.
   logic       wr_serial_enable;
   logic       wr_clock_timer_enable;
   logic       wr_upper_timer_enable;
   logic       wr_port_flags;
   logic       wr_lower_timer_flags;
   logic       wr_serial_flags;

   // Clear masks; all zero unless a write hits the register.
   logic [7:0] clr_port;
   logic [7:0] clr_lower_timer;
   logic [5:0] clr_serial;

   // Next register values, merged into the state by the process below.
   logic [5:0] next_serial_enable;
   logic [3:0] next_clock_timer_enable;
   logic [7:0] next_upper_timer_enable;
   logic [7:0] next_port_flags;
   logic [7:0] next_lower_timer_flags;
   logic [5:0] next_serial_flags;

   // Named fields of the narrow registers, taken from the next values.
   logic       ser1_error_irq_en;
   logic       ser1_receive_irq_en;
   logic       ser1_transmit_irq_en;
   logic       ser0_error_irq_en;
   logic       ser0_receive_irq_en;
   logic       ser0_transmit_irq_en;
   logic       tick_32hz_irq_en;
   logic       tick_8hz_irq_en;
   logic       tick_2hz_irq_en;
   logic       tick_1hz_irq_en;
   logic       ser1_error_flag;
   logic       ser1_receive_flag;
   logic       ser1_transmit_flag;
   logic       ser0_error_flag;
   logic       ser0_receive_flag;
   logic       ser0_transmit_flag;

   // Read words of the narrow registers, rebuilt field by field.
   logic [7:0] rd_serial_enable;
   logic [7:0] rd_clock_timer_enable;
   logic [7:0] rd_serial_flags;

   // Only whole-word transfers are expected; size is accepted but not checked.
   assign addr_phase     = hsel & hready & (htrans == irqf_pkg::HTRANS_NONSEQ);
   assign addr_in_window = (haddr[31:18] == 14'h0000);
   assign addr_aligned   = (haddr[1:0] == 2'b00);
   assign addr_index     = haddr[17:2];
   assign wr_en          = state.dp_valid & state.dp_write & state.dp_mapped;
   assign wbyte          = hwdata[7:0];

   // Unlisted indices match no strobe, so writes to them fall away.
   assign wr_serial_enable =
      wr_en & (state.dp_index == irqf_pkg::IDX_SERIAL_IRQ_ENABLE);
   assign wr_clock_timer_enable =
      wr_en & (state.dp_index == irqf_pkg::IDX_CLOCK_TIMER_IRQ_ENABLE);
   assign wr_upper_timer_enable =
      wr_en & (state.dp_index == irqf_pkg::IDX_UPPER_TIMER_IRQ_ENABLE);
   assign wr_port_flags =
      wr_en & (state.dp_index == irqf_pkg::IDX_PORT_IRQ_FLAGS);
   assign wr_lower_timer_flags =
      wr_en & (state.dp_index == irqf_pkg::IDX_LOWER_TIMER_IRQ_FLAGS);
   assign wr_serial_flags =
      wr_en & (state.dp_index == irqf_pkg::IDX_SERIAL_IRQ_FLAGS);

   assign clr_port        = wr_port_flags ? wbyte : 8'h00;
   assign clr_lower_timer = wr_lower_timer_flags ? wbyte : 8'h00;
   assign clr_serial      = wr_serial_flags ? wbyte[5:0] : 6'h00;

   assign next_serial_enable =
      wr_serial_enable ? wbyte[5:0] : state.serial_irq_enable;
   assign next_clock_timer_enable =
      wr_clock_timer_enable ? wbyte[3:0] : state.clock_timer_irq_enable;
   assign next_upper_timer_enable =
      wr_upper_timer_enable ? wbyte : state.upper_timer_irq_enable;

   // cause sets flag
   // One cell per bit; the serial register has only six. The event term is
   // ORed in last, so a cause that arrives in the clearing cycle is kept.
   for (genvar i = 0; i < 8; i++) begin : g_flag
      assign next_port_flags[i] =
         (state.port_irq_flags[i] & ~clr_port[i]) | events.port[i];
      assign next_lower_timer_flags[i] =
         (state.lower_timer_irq_flags[i] & ~clr_lower_timer[i])
         | events.lower_timer[i];
      if (i < 6) begin : g_serial
         assign next_serial_flags[i] =
            (state.serial_irq_flags[i] & ~clr_serial[i]) | events.serial[i];
      end
   end

   assign ser1_error_irq_en    = next_serial_enable[irqf_pkg::SER1_ERROR];
   assign ser1_receive_irq_en  = next_serial_enable[irqf_pkg::SER1_RECEIVE];
   assign ser1_transmit_irq_en = next_serial_enable[irqf_pkg::SER1_TRANSMIT];
   assign ser0_error_irq_en    = next_serial_enable[irqf_pkg::SER0_ERROR];
   assign ser0_receive_irq_en  = next_serial_enable[irqf_pkg::SER0_RECEIVE];
   assign ser0_transmit_irq_en = next_serial_enable[irqf_pkg::SER0_TRANSMIT];
   assign tick_32hz_irq_en     = next_clock_timer_enable[irqf_pkg::TICK_32HZ];
   assign tick_8hz_irq_en      = next_clock_timer_enable[irqf_pkg::TICK_8HZ];
   assign tick_2hz_irq_en      = next_clock_timer_enable[irqf_pkg::TICK_2HZ];
   assign tick_1hz_irq_en      = next_clock_timer_enable[irqf_pkg::TICK_1HZ];
   assign ser1_error_flag      = next_serial_flags[irqf_pkg::SER1_ERROR];
   assign ser1_receive_flag    = next_serial_flags[irqf_pkg::SER1_RECEIVE];
   assign ser1_transmit_flag   = next_serial_flags[irqf_pkg::SER1_TRANSMIT];
   assign ser0_error_flag      = next_serial_flags[irqf_pkg::SER0_ERROR];
   assign ser0_receive_flag    = next_serial_flags[irqf_pkg::SER0_RECEIVE];
   assign ser0_transmit_flag   = next_serial_flags[irqf_pkg::SER0_TRANSMIT];

   // Building the words from named fields keeps the layout in one place,
   // the package positions, rather than in a second hand-written pattern.
   always_comb begin
      rd_serial_enable                          = 8'h00;
      rd_serial_enable[irqf_pkg::SER1_ERROR]    = ser1_error_irq_en;
      rd_serial_enable[irqf_pkg::SER1_RECEIVE]  = ser1_receive_irq_en;
      rd_serial_enable[irqf_pkg::SER1_TRANSMIT] = ser1_transmit_irq_en;
      rd_serial_enable[irqf_pkg::SER0_ERROR]    = ser0_error_irq_en;
      rd_serial_enable[irqf_pkg::SER0_RECEIVE]  = ser0_receive_irq_en;
      rd_serial_enable[irqf_pkg::SER0_TRANSMIT] = ser0_transmit_irq_en;

      rd_clock_timer_enable                      = 8'h00;
      rd_clock_timer_enable[irqf_pkg::TICK_32HZ] = tick_32hz_irq_en;
      rd_clock_timer_enable[irqf_pkg::TICK_8HZ]  = tick_8hz_irq_en;
      rd_clock_timer_enable[irqf_pkg::TICK_2HZ]  = tick_2hz_irq_en;
      rd_clock_timer_enable[irqf_pkg::TICK_1HZ]  = tick_1hz_irq_en;

      rd_serial_flags                          = 8'h00;
      rd_serial_flags[irqf_pkg::SER1_ERROR]    = ser1_error_flag;
      rd_serial_flags[irqf_pkg::SER1_RECEIVE]  = ser1_receive_flag;
      rd_serial_flags[irqf_pkg::SER1_TRANSMIT] = ser1_transmit_flag;
      rd_serial_flags[irqf_pkg::SER0_ERROR]    = ser0_error_flag;
      rd_serial_flags[irqf_pkg::SER0_RECEIVE]  = ser0_receive_flag;
      rd_serial_flags[irqf_pkg::SER0_TRANSMIT] = ser0_transmit_flag;
   end

   always_comb begin
      next_state = state;

      next_state.serial_irq_enable      = next_serial_enable;
      next_state.clock_timer_irq_enable = next_clock_timer_enable;
      next_state.upper_timer_irq_enable = next_upper_timer_enable;
      next_state.port_irq_flags         = next_port_flags;
      next_state.lower_timer_irq_flags  = next_lower_timer_flags;
      next_state.serial_irq_flags       = next_serial_flags;

      // Read data is taken from the updated values so a read right after a
      // write, or after an event, already shows it.
      rd_mux = 8'h00;
      case (addr_index)
         irqf_pkg::IDX_SERIAL_IRQ_ENABLE: begin
            rd_mux = rd_serial_enable & irqf_pkg::MASK_SERIAL;
         end
         irqf_pkg::IDX_CLOCK_TIMER_IRQ_ENABLE: begin
            rd_mux = rd_clock_timer_enable & irqf_pkg::MASK_CLOCK_TIMER;
         end
         irqf_pkg::IDX_UPPER_TIMER_IRQ_ENABLE: begin
            rd_mux = next_state.upper_timer_irq_enable & irqf_pkg::MASK_FULL;
         end
         irqf_pkg::IDX_PORT_IRQ_FLAGS: begin
            rd_mux = next_state.port_irq_flags;
         end
         irqf_pkg::IDX_LOWER_TIMER_IRQ_FLAGS: begin
            rd_mux = next_state.lower_timer_irq_flags;
         end
         irqf_pkg::IDX_SERIAL_IRQ_FLAGS: begin
            rd_mux = rd_serial_flags & irqf_pkg::MASK_SERIAL;
         end
         default: begin
            rd_mux = 8'h00;
         end
      endcase

      next_state.dp_valid = addr_phase;
      if (addr_phase) begin
         next_state.dp_write  = hwrite;
         next_state.dp_index  = addr_index;
         next_state.dp_mapped = addr_in_window && addr_aligned;
         // A misaligned read selects no register and returns zero.
         next_state.rdata     = (!hwrite && addr_in_window && addr_aligned) ? rd_mux : 8'h00;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state.dp_valid               <= 1'b0;
         state.dp_write               <= 1'b0;
         state.dp_index               <= 16'h0000;
         state.dp_mapped              <= 1'b0;
         state.rdata                  <= 8'h00;
         state.serial_irq_enable      <= irqf_pkg::RST_ENABLE[5:0];
         state.clock_timer_irq_enable <= irqf_pkg::RST_ENABLE[3:0];
         state.upper_timer_irq_enable <= irqf_pkg::RST_ENABLE;
         state.port_irq_flags         <= irqf_pkg::RST_FLAGS;
         state.lower_timer_irq_flags  <= irqf_pkg::RST_FLAGS;
         state.serial_irq_flags       <= irqf_pkg::RST_FLAGS[5:0];
      end else begin
         state <= next_state;
      end
   end

   // Zero wait states; every transfer is answered OKAY.
   assign hreadyout = 1'b1;
   assign hresp     = irqf_pkg::HRESP_OKAY;
   assign hrdata    = {24'h000000, state.rdata};

   assign status.serial_irq_req         = state.serial_irq_flags & state.serial_irq_enable;
   assign status.clock_timer_irq_enable = state.clock_timer_irq_enable;
   assign status.upper_timer_irq_enable = state.upper_timer_irq_enable;
   assign status.port_irq_flags         = state.port_irq_flags;
   assign status.lower_timer_irq_flags  = state.lower_timer_irq_flags;

endmodule

`default_nettype wire

// ### irqf_top_tb.sv
// Testbench for the interrupt enable and flag block.
// Speaks AHB-Lite single word transfers; events come from the source model.
`timescale 1ns/1ns
`default_nettype none
module irqf_top_tb;
   logic                   hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic                   hreadyout, hresp;
   logic [1:0]             htrans = 2'h0;
   logic [31:0]            haddr = '0, hwdata = '0, hrdata, rd;
   logic [15:0]            regs [6] = '{16'hff16, 16'hff17, 16'hff18, 16'hff1a, 16'hff1b, 16'hff1c};
   irqf_pkg::irqf_events_t events;
   irqf_pkg::irqf_status_t status;
   int                     num_errors = 0, num_checks = 0;
   irqf_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .events(events), .status(status));
   irqf_evsrc src_u (.hclk(hclk), .events(events));
   always #5 hclk = ~hclk;
   task automatic end_sim;
      $display("errors %0d checks %0d", num_errors, num_checks);
      if (num_errors == 0 && num_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", n, exp, got);
      end
   endtask
   // Bounded wait for hready at a rising edge.
   task automatic wait_rdy;
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 50);
      if (hreadyout !== 1'b1) begin
         num_errors++;
         end_sim;
      end
   endtask
   task automatic xfer(input logic w, input logic [15:0] idx, input logic [7:0] wd);
      hsel <= 1'b1;
      haddr <= {14'h0000, idx, 2'b00};
      hwrite <= w;
      htrans <= irqf_pkg::HTRANS_NONSEQ;
      wait_rdy;
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {24'h000000, wd};
      wait_rdy;
      rd = hrdata;
   endtask
   task automatic rchk(input string n, input logic [15:0] idx, input logic [31:0] exp);
      xfer(1'b0, idx, 8'h00);
      chk(n, rd, exp);
   endtask
   initial begin
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      foreach (regs[i]) rchk("reset", regs[i], 32'h0);
      foreach (regs[i]) xfer(1'b1, regs[i], 8'hff);
      rchk("ser_en", regs[0], 32'h3f);
      rchk("ct_en", regs[1], 32'h0f);
      rchk("up_en", regs[2], 32'hff);
      xfer(1'b1, 16'hff19, 8'hff);
      rchk("unmapped", 16'hff19, 32'h0);
      chk("st_en", 32'({status.clock_timer_irq_enable, status.upper_timer_irq_enable}), 32'hfff);
      src_u.pulse('{port: 8'ha5, lower_timer: 8'h3c, serial: 6'h21});
      rchk("port_f", regs[3], 32'ha5);
      rchk("lt_f", regs[4], 32'h3c);
      rchk("ser_f", regs[5], 32'h21);
      chk("req", 32'(status.serial_irq_req), 32'h21);
      xfer(1'b1, regs[3], 8'h05);
      rchk("port_w1c", regs[3], 32'ha0);
      xfer(1'b1, regs[5], 8'h20);
      rchk("ser_w1c", regs[5], 32'h01);
      xfer(1'b1, regs[4], 8'h3c);
      rchk("lt_w1c", regs[4], 32'h0);
      xfer(1'b1, regs[0], 8'h00);
      rchk("ser_en0", regs[0], 32'h0);
      chk("req_off", 32'(status.serial_irq_req), 32'h0);
      hresetn <= 1'b0;
      @(posedge hclk);
      hresetn <= 1'b1;
      rchk("port_rst", regs[3], 32'h0);
      rchk("up_rst", regs[2], 32'h0);
      end_sim;
   end
endmodule
`default_nettype wire
